// file: inc/interval_timer_pkg.sv
package interval_timer_pkg;

    // Register map
    localparam logic [5:0] DELAY_CTRL_ADDR = 6'h0d;
    localparam logic [5:0] RESERVED_BITS_FILL_ADDR = 6'h0e;
    localparam logic [15:0] DELAY_CTRL_RESET = 16'h2201;
    localparam logic [7:0] RESERVED_BITS_FILL_RESET = 8'hff;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // Field positions of the delay control register
    localparam int AUX_EN_BIT = 15;
    localparam int AUX_IV_LSB = 12;
    localparam int TOUCH_EN_BIT = 11;
    localparam int TOUCH_IV_LSB = 8;
    localparam int SRC_SEL_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam int IV_W = 3;
    localparam int DIV_W = 7;

    // Interval codes with special meaning
    localparam logic [2:0] AUX_CODE_UNDEF = 3'h6;
    localparam logic [2:0] AUX_CODE_SUBST = 3'h5;
    localparam logic [6:0] DIV_CODE_ZERO = 7'h00;
    localparam logic [7:0] DIV_ZERO_VALUE = 8'h80;

    // Clock and tick rates
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int TICK_HZ = 1_000_000;
    localparam int TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
    localparam int US_PER_MIN = 60_000_000;
    localparam int US_PER_CMIN = US_PER_MIN / 100;

    // Waits: touch in microseconds, aux in hundredths of a minute
    localparam int TOUCH_US [8] = '{1000, 3000, 5000, 6500,
                                    8500, 10000, 12500, 15000};
    localparam int AUX_CMIN [8] = '{112, 336, 559, 783,
                                    1001, 1230, 1230, 1678};

    localparam int CNT_W = 30;

    typedef logic [CNT_W-1:0] count_t;
    typedef count_t [7:0] wait_table_t;

    // Microsecond counts derived from the printed times
    localparam wait_table_t TOUCH_WAIT_TICKS = '{
        count_t'(TOUCH_US[7]), count_t'(TOUCH_US[6]),
        count_t'(TOUCH_US[5]), count_t'(TOUCH_US[4]),
        count_t'(TOUCH_US[3]), count_t'(TOUCH_US[2]),
        count_t'(TOUCH_US[1]), count_t'(TOUCH_US[0])};
    localparam wait_table_t AUX_WAIT_TICKS = '{
        count_t'(AUX_CMIN[7] * US_PER_CMIN),
        count_t'(AUX_CMIN[6] * US_PER_CMIN),
        count_t'(AUX_CMIN[5] * US_PER_CMIN),
        count_t'(AUX_CMIN[4] * US_PER_CMIN),
        count_t'(AUX_CMIN[3] * US_PER_CMIN),
        count_t'(AUX_CMIN[2] * US_PER_CMIN),
        count_t'(AUX_CMIN[1] * US_PER_CMIN),
        count_t'(AUX_CMIN[0] * US_PER_CMIN)};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } timer_state_t;

    // Sequencer status from the conversion logic
    typedef struct packed {
        logic set_done;
        logic set_is_touch;
        logic touch_self_mode;
        logic touch_cont_scan;
        logic auto_temperature_enable;
        logic auto_first_aux_enable;
        logic auto_second_aux_enable;
    } seq_status_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        timer_state_t state;
        logic [15:0] ctrl;
        logic [7:0] reserved_bits;
        logic [15:0] rdata;
        logic [1:0] mclk_sync;
        logic mclk_prev;
        logic [5:0] sys_div;
        logic [7:0] mclk_div;
        logic tick;
        count_t count;
        count_t target;
        logic start_next;
        logic waiting;
    } timer_state_vec_t;

endpackage

// file: core/conversion_interval_timer.sv
`timescale 1ns/1ps

module conversion_interval_timer #(
    parameter interval_timer_pkg::wait_table_t TOUCH_WAIT =
        interval_timer_pkg::TOUCH_WAIT_TICKS,
    parameter interval_timer_pkg::wait_table_t AUX_WAIT =
        interval_timer_pkg::AUX_WAIT_TICKS,
    parameter int TICK_CYCLES = interval_timer_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic mclk_pin,
    input wire interval_timer_pkg::reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input wire interval_timer_pkg::seq_status_t seq_status,
    output logic start_next_set,
    output logic wait_active
);

    // Tick divider must fit its counter and give at least two cycles
    if (TICK_CYCLES < 2 || TICK_CYCLES > 64) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // Last count of the internal tick divider
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

    interval_timer_pkg::timer_state_vec_t s_reg;
    interval_timer_pkg::timer_state_vec_t s_next;

    // Divider code to divide ratio
    function automatic logic [7:0] div_ratio(input logic [6:0] code);
        if (code == interval_timer_pkg::DIV_CODE_ZERO) begin
            div_ratio = interval_timer_pkg::DIV_ZERO_VALUE;
        end else begin
            div_ratio = {1'b0, code};
        end
    endfunction

    // Aux code with the undefined value folded onto its neighbour
    function automatic logic [2:0] aux_code(input logic [2:0] code);
        if (code == interval_timer_pkg::AUX_CODE_UNDEF) begin
            aux_code = interval_timer_pkg::AUX_CODE_SUBST;
        end else begin
            aux_code = code;
        end
    endfunction

    // Decoded control fields and wait qualifiers
    logic [15:0] ctrl;
    logic aux_en;
    logic touch_en;
    logic src_ext;
    logic [2:0] aux_iv;
    logic [2:0] touch_iv;
    logic [6:0] div_code;
    logic mclk_rise;
    logic touch_wait_ok;
    logic aux_wait_ok;

    // Field decode of the control register
    assign ctrl = s_reg.ctrl;
    assign aux_en = ctrl[interval_timer_pkg::AUX_EN_BIT];
    assign touch_en = ctrl[interval_timer_pkg::TOUCH_EN_BIT];
    assign src_ext = ctrl[interval_timer_pkg::SRC_SEL_BIT];
    assign aux_iv = ctrl[interval_timer_pkg::AUX_IV_LSB +:
                         interval_timer_pkg::IV_W];
    assign touch_iv = ctrl[interval_timer_pkg::TOUCH_IV_LSB +:
                           interval_timer_pkg::IV_W];
    assign div_code = ctrl[interval_timer_pkg::DIV_LSB +:
                           interval_timer_pkg::DIV_W];

    // Rising edge of the synchronised master clock
    assign mclk_rise = s_reg.mclk_sync[1] & ~s_reg.mclk_prev;

    // Which kinds of set get a wait
    assign touch_wait_ok = touch_en &
                           (seq_status.touch_self_mode |
                            seq_status.touch_cont_scan);
    assign aux_wait_ok = aux_en &
                         (seq_status.auto_temperature_enable |
                          seq_status.auto_first_aux_enable |
                          seq_status.auto_second_aux_enable);

    always_comb begin
        s_next = s_reg;
        s_next.start_next = 1'b0;
        s_next.tick = 1'b0;

        // Master clock is only a timing reference, never a conversion clock
        // Two flip-flops stand before any logic reads the pin
        s_next.mclk_sync = {s_reg.mclk_sync[0], mclk_pin};
        s_next.mclk_prev = s_reg.mclk_sync[1];

        // One microsecond tick from the chosen source
        // Unused divider held at zero so a source switch starts cleanly
        if (src_ext) begin
            s_next.sys_div = '0;
            // Pin must toggle slower than half of clk_sys or edges are lost
            if (mclk_rise) begin
                if (s_reg.mclk_div + 8'h01 >= div_ratio(div_code)) begin
                    s_next.mclk_div = '0;
                    s_next.tick = 1'b1;
                end else begin
                    s_next.mclk_div = s_reg.mclk_div + 8'h01;
                end
            end
        end else begin
            s_next.mclk_div = '0;
            if (s_reg.sys_div >= TICK_LAST) begin
                s_next.sys_div = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.sys_div = s_reg.sys_div + 6'h01;
            end
        end

        // Register writes; reserved byte is plain storage
        // Writes to other addresses are dropped without an error
        if (reg_req.wr) begin
            if (reg_req.addr == interval_timer_pkg::DELAY_CTRL_ADDR) begin
                s_next.ctrl = reg_req.wdata;
            end else if (reg_req.addr ==
                         interval_timer_pkg::RESERVED_BITS_FILL_ADDR) begin
                s_next.reserved_bits = reg_req.wdata[15:8];
            end
        end

        // Register reads, unmapped reads give zero
        // A read beside a write returns the old value
        if (reg_req.rd) begin
            if (reg_req.addr == interval_timer_pkg::DELAY_CTRL_ADDR) begin
                s_next.rdata = s_reg.ctrl;
            end else if (reg_req.addr ==
                         interval_timer_pkg::RESERVED_BITS_FILL_ADDR) begin
                s_next.rdata = {s_reg.reserved_bits, 8'h00};
            end else begin
                s_next.rdata = interval_timer_pkg::READ_ZERO;
            end
        end

        case (s_reg.state)
            interval_timer_pkg::ST_IDLE: begin
                // Wait begins at the end of a set
                // Only idle takes set_done; one during a wait is dropped
                if (seq_status.set_done) begin
                    s_next.count = '0;
                    // Target latched here so mid-wait writes cannot stretch it
                    if (seq_status.set_is_touch && touch_wait_ok) begin
                        s_next.target = TOUCH_WAIT[touch_iv];
                        s_next.state = interval_timer_pkg::ST_WAIT;
                        s_next.waiting = 1'b1;
                    end else if (!seq_status.set_is_touch && aux_wait_ok) begin
                        s_next.target = AUX_WAIT[aux_code(aux_iv)];
                        s_next.state = interval_timer_pkg::ST_WAIT;
                        s_next.waiting = 1'b1;
                    end else begin
                        s_next.start_next = 1'b1;
                    end
                end
            end
            interval_timer_pkg::ST_WAIT: begin
                // Ticks are counted until the interval is reached
                if (s_reg.tick) begin
                    if (s_reg.count + 30'h1 >= s_reg.target) begin
                        s_next.start_next = 1'b1;
                        s_next.state = interval_timer_pkg::ST_IDLE;
                        s_next.waiting = 1'b0;
                    end else begin
                        s_next.count = s_reg.count + 30'h1;
                    end
                end
            end
            // Illegal state codes fall back to idle
            default: begin
                s_next.state = interval_timer_pkg::ST_IDLE;
                s_next.waiting = 1'b0;
            end
        endcase
    end

    // Single state register; reset values fixed by the package
    // Reset branch loads constants only, so release is clean
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.state <= interval_timer_pkg::ST_IDLE;
            s_reg.ctrl <= interval_timer_pkg::DELAY_CTRL_RESET;
            s_reg.reserved_bits <= interval_timer_pkg::RESERVED_BITS_FILL_RESET;
            s_reg.rdata <= interval_timer_pkg::READ_ZERO;
            s_reg.mclk_sync <= '0;
            s_reg.mclk_prev <= 1'b0;
            s_reg.sys_div <= '0;
            s_reg.mclk_div <= '0;
            s_reg.tick <= 1'b0;
            s_reg.count <= '0;
            s_reg.target <= '0;
            s_reg.start_next <= 1'b0;
            s_reg.waiting <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = s_reg.rdata;
    assign start_next_set = s_reg.start_next;
    assign wait_active = s_reg.waiting;

endmodule

// file: sim/timer_checker_props.sv
`timescale 1ns/1ps
module timer_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic mclk_pin,
    input wire interval_timer_pkg::reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire interval_timer_pkg::seq_status_t seq_status,
    input wire logic start_next_set,
    input wire logic wait_active
);
    logic [15:0] ctrl_reg;
    logic [7:0] reserved_bits_reg;
    logic take;
    logic tch_on;
    logic aux_on;
    // Shadow of the registers, built from port traffic only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= 16'h2201;
            reserved_bits_reg <= 8'hff;
        end else if (reg_req.wr && reg_req.addr == 6'h0d) begin
            ctrl_reg <= reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == 6'h0e) begin
            reserved_bits_reg <= reg_req.wdata[15:8];
        end
    end
    // Which kind of wait the next set should get
    assign take = seq_status.set_done && !wait_active;
    assign tch_on = seq_status.set_is_touch && ctrl_reg[11]
        && (seq_status.touch_self_mode || seq_status.touch_cont_scan);
    assign aux_on = !seq_status.set_is_touch && ctrl_reg[15]
        && (seq_status.auto_temperature_enable
        || seq_status.auto_first_aux_enable
        || seq_status.auto_second_aux_enable);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_touch_wait;
        take && tch_on |=> wait_active && !start_next_set;
    endproperty
    a_touch_wait: assert property (p_touch_wait)
        else $error("touch wait missing");
    property p_touch_skip;
        take && seq_status.set_is_touch && !tch_on |=> start_next_set;
    endproperty
    a_touch_skip: assert property (p_touch_skip)
        else $error("touch set not released at once");
    property p_aux_wait;
        take && aux_on |=> wait_active && !start_next_set;
    endproperty
    a_aux_wait: assert property (p_aux_wait)
        else $error("aux wait missing");
    property p_aux_skip;
        take && !seq_status.set_is_touch && !aux_on |=> start_next_set;
    endproperty
    a_aux_skip: assert property (p_aux_skip)
        else $error("aux set not released at once");
    property p_wait_end;
        $fell(wait_active) |-> start_next_set;
    endproperty
    a_wait_end: assert property (p_wait_end)
        else $error("wait ended without start");
    property p_pulse_once;
        start_next_set |=> !start_next_set && !wait_active;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("start pulse too long");
    property p_rd_ctrl;
        reg_req.rd && reg_req.addr == 6'h0d |=> reg_rdata == $past(ctrl_reg);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control readback wrong");
    property p_rd_reserved_bits;
        reg_req.rd && reg_req.addr == 6'h0e
            |=> reg_rdata == {$past(reserved_bits_reg), 8'h00};
    endproperty
    a_rd_reserved_bits: assert property (p_rd_reserved_bits)
        else $error("reserved readback wrong");
endmodule

bind conversion_interval_timer timer_checker timer_checker_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .mclk_pin(mclk_pin),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .seq_status(seq_status),
    .start_next_set(start_next_set), .wait_active(wait_active));

// file: sim/conversion_interval_timer_tb_top.sv
`timescale 1ns/1ps
module conversion_interval_timer_tb_top;
    // Short tick and short tables keep the run small
    localparam int TC = 4;
    localparam interval_timer_pkg::wait_table_t TW =
        {30'h9, 30'h8, 30'h7, 30'h6, 30'h5, 30'h4, 30'h3, 30'h2};
    // Entry 6 differs from entry 5 so the code 110 fold is visible
    localparam interval_timer_pkg::wait_table_t AW =
        {30'ha, 30'h9, 30'h8, 30'h7, 30'h6, 30'h5, 30'h4, 30'h3};
    typedef struct {int lo; int hi;} note_t;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic mclk_pin = 1'b0;
    interval_timer_pkg::reg_req_t reg_req = '0;
    interval_timer_pkg::seq_status_t seq_status = '0;
    logic [15:0] reg_rdata;
    logic start_next_set;
    logic wait_active;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic rd_seen = 1'b0;
    logic [31:0] rng = 32'h0000_001e; // Seed 30
    logic [15:0] rd_q[$];
    note_t gap_q[$];

    always #12.5 clk_sys = ~clk_sys;
    // Master clock of 10 MHz: one tick per divider step is 4 cycles
    always #50 mclk_pin = ~mclk_pin;

    conversion_interval_timer #(.TOUCH_WAIT(TW), .AUX_WAIT(AW),
        .TICK_CYCLES(TC)) conversion_interval_timer_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .mclk_pin(mclk_pin),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .seq_status(seq_status),
        .start_next_set(start_next_set), .wait_active(wait_active));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // Tick phase is free running, so a wait is only known to a tick
    function automatic note_t nt(input int n, input int t, input int s);
        nt.lo = (n - 1) * t;
        nt.hi = n * t + s;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk16(input string nm, input logic [15:0] e,
        input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic chk_gap(input note_t n, input int s);
        samples_checked++;
        if (s < n.lo || s > n.hi) begin
            bad_count++;
            $display("MISMATCH gap exp %0d..%0d got %0d", n.lo, n.hi, s);
        end
    endtask

    // Watcher: read data one cycle after the strobe, gap at each start
    always @(posedge clk_sys) begin
        if (rd_seen) chk16("rdata", rd_q.pop_front(), reg_rdata);
        if (start_next_set === 1'b1) chk_gap(gap_q.pop_front(), cyc);
        rd_seen = reg_req.rd;
        cyc = (seq_status.set_done && !wait_active) ? 1 : cyc + 1;
    end

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge clk_sys) #1 reg_req.wr = 1'b0;
        // Idle edge so a following strobe is never set in this time step
        @(posedge clk_sys) #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(posedge clk_sys) #1 reg_req.rd = 1'b0;
        @(posedge clk_sys) #1;
    endtask
    // One set ends; wait for the release under a bound
    task automatic setc(input logic tch, input note_t n);
        int i;
        gap_q.push_back(n);
        seq_status.set_done = 1'b1;
        seq_status.set_is_touch = tch;
        @(posedge clk_sys) #1 seq_status.set_done = 1'b0;
        for (i = 0; i < 3000 && start_next_set !== 1'b1; i++) begin
            @(posedge clk_sys) #1;
        end
        if (i == 3000) begin
            bad_count++;
            report_and_stop;
        end
        repeat (2) @(posedge clk_sys) #1;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        rd(6'h0d, 16'h2201);
        rd(6'h0e, 16'hff00);
        rd(6'h0c, 16'h0000);
        wr(6'h0e, 16'hff00);
        rd(6'h0e, 16'hff00);
        rng = xs(rng);
        wr(6'h0d, rng[15:0]);
        rd(6'h0d, rng[15:0]);
        $display("registers done");
        seq_status.touch_self_mode = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(6'h0d, {4'h0, 1'b1, 3'(c), 8'h01});
            setc(1'b1, nt(int'(TW[c]), TC, 3));
        end
        seq_status.touch_self_mode = 1'b0;
        setc(1'b1, '{1, 1});
        seq_status.touch_cont_scan = 1'b1;
        setc(1'b1, nt(int'(TW[7]), TC, 3));
        wr(6'h0d, 16'h0001);
        setc(1'b1, '{1, 1});
        $display("touch done");
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            {seq_status.auto_temperature_enable,
                seq_status.auto_first_aux_enable,
                seq_status.auto_second_aux_enable} = rng[2:0] | 3'b001;
            wr(6'h0d, {1'b1, 3'(c), 12'h001});
            setc(1'b0, nt(int'(AW[(c == 6) ? 5 : c]), TC, 3));
        end
        seq_status.auto_first_aux_enable = 1'b0;
        seq_status.auto_second_aux_enable = 1'b0;
        seq_status.auto_temperature_enable = 1'b0;
        setc(1'b0, '{1, 1});
        seq_status.auto_second_aux_enable = 1'b1;
        wr(6'h0d, 16'h2001);
        setc(1'b0, '{1, 1});
        $display("aux done");
        wr(6'h0d, 16'h0882);
        setc(1'b1, nt(int'(TW[0]), 8, 8));
        wr(6'h0d, 16'h0880);
        setc(1'b1, nt(int'(TW[0]), 512, 8));
        $display("master clock done");
        // Reset in mid-run must bring back the reset values
        rng = xs(rng);
        wr(6'h0d, rng[15:0]);
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        rd(6'h0d, 16'h2201);
        rd(6'h0e, 16'hff00);
        $display("reset done");
        report_and_stop;
    end
endmodule
